// ---- hdl/mastership_arbiter.sv ----
// processor-side arbiter handing the external bus to an outside master
//
// What this block does
// - two grant-withdrawal protocols, picked by one select bit; clear means default
// - default protocol keeps grant asserted while the request stays asserted
// - alternative protocol drops grant early when the core needs the bus
// - grant is never withdrawn before being low for 1.5 system periods
// - bus outputs resume only after the outside master drops its request
// - request is active low; its negation is sampled on a rising system edge
// - default protocol negates grant on the falling edge after release sampled
// - alternative protocol negates a still-low grant on the next falling edge
// - bus outputs re-enable on the first rising edge after release sampled
// - request seen and bus idle: grant and tri-state from a rising edge
// - request during a transfer waits for the next slot after it ends
// - alternative protocol raises grant when held 1.5 periods and access pending
// - extended data enable tri-states half a clock later, driven high first
// - core runs from cache while granted away, stalling only for bus access
// - no coherency between outside transfers and caches; software handles it
// - grant follows request assertion; mastership returns on its negation
// - bus, address, controls, strobes and diagnostics float while granted away
// - read buffer enable, acknowledge and error inputs ignored while granted away
// - grant, system clock and timer count keep driving while granted away
`timescale 1ns/1ps
`include "mastership_regs.svh"

module mastership_arbiter #(
    parameter int HOLD_CYCLES = `GRANT_MIN_HOLD_CYCLES
) (
    // clock and reset
    input  wire logic core_clk_in,
    input  wire logic resetn_in,
    // configuration: set selects the early-withdrawal protocol
    input  wire logic protocol_select_in,
    // outside master handshake
    input  wire logic mastership_request_n_in,
    output logic      mastership_grant_n_out,
    // core side status
    input  wire logic cpu_bus_need_in,
    input  wire logic transfer_busy_in,
    output logic      cpu_stall_out,
    // bus drive control for the tri-stated bus outputs other than the extended data enable pin
    output logic      bus_output_enable_out,
    // extended data enable pin, its value from the transfer engine
    input  wire logic ext_data_enable_n_in,
    output logic      extended_data_enable_n_out,
    output logic      extended_data_enable_oe_out,
    // bus inputs as seen by the transfer engine
    input  wire logic read_buffer_clock_enable_n_in,
    input  wire logic ack_n_in,
    input  wire logic transfer_error_n_in,
    output logic      read_buffer_clock_enable_n_out,
    output logic      ack_n_out,
    output logic      transfer_error_n_out,
    // pins that keep driving throughout
    input  wire logic timer_terminal_count_n_in,
    output logic      system_clock_out,
    output logic      timer_terminal_count_n_out
);

    mastership_pkg::owner_state_t state;
    mastership_pkg::owner_state_t next_state;

    logic                    request_sync_n;
    logic [`GRANT_CNT_W-1:0] hold_cnt;
    logic                    next_grant_n;
    logic                    next_bus_oe;

    // request crosses in through two flops before anything looks at it
    level_sync #(
        .WIDTH       (1),
        .RESET_VALUE (1'b1)
    ) u_request_sync (
        .clk_in    (core_clk_in),
        .resetn_in (resetn_in),
        .async_in  (mastership_request_n_in),
        .sync_out  (request_sync_n)
    );

    // system clock toggles every core cycle; low now means rising next edge
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            system_clock_out <= 1'b0;
        else
            system_clock_out <= ~system_clock_out;
    end

    // edge qualifiers and decoded conditions
    wire rise_edge   = ~system_clock_out;
    wire fall_edge   = system_clock_out;
    wire request_on  = ~request_sync_n;
    wire alt_proto   = protocol_select_in;
    wire granted_out = ~bus_output_enable_out;
    wire hold_met    = hold_cnt >= `GRANT_CNT_W'(HOLD_CYCLES - 1);
    wire grant_low   = ~mastership_grant_n_out;

    // grant starts only at a rising edge with the bus free of transfers
    wire start_grant = rise_edge & request_on & ~transfer_busy_in;

    // early withdrawal: only in the alternative protocol, only once held long enough
    wire early_drop  = alt_proto & rise_edge & grant_low & hold_met
                     & cpu_bus_need_in;

    // release of the request is only seen at rising edges
    wire release_seen = rise_edge & ~request_on;

    // grant may go high at the falling edge after release if held long enough
    wire release_drop = fall_edge & (hold_met | ~grant_low);

    // next-state and output decode
    always_comb
    begin
        next_state   = state;
        next_grant_n = mastership_grant_n_out;
        next_bus_oe  = bus_output_enable_out;
        unique case (state)
            mastership_pkg::CPU_OWNS:
            begin
                next_bus_oe = 1'b1;
                if (start_grant)
                begin
                    next_grant_n = 1'b0;
                    next_bus_oe  = 1'b0;
                    next_state   = mastership_pkg::GRANTED;
                end
            end
            mastership_pkg::GRANTED:
            begin
                // default protocol holds grant while request stays on
                if (early_drop)
                    next_grant_n = 1'b1;
                if (release_seen)
                    next_state = mastership_pkg::RELEASING;
            end
            mastership_pkg::RELEASING:
            begin
                if (release_drop)
                begin
                    next_grant_n = 1'b1;
                    next_state   = mastership_pkg::RESUMING;
                end
            end
            mastership_pkg::RESUMING:
            begin
                // bus stays floating until this rising edge
                if (rise_edge)
                begin
                    next_bus_oe = 1'b1;
                    next_state  = mastership_pkg::CPU_OWNS;
                end
            end
        endcase
    end

    // state, grant and bus enable flops; grant negated during reset
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state                  <= mastership_pkg::CPU_OWNS;
            mastership_grant_n_out <= `GRANT_RESET_N;
            bus_output_enable_out  <= 1'b0;
        end
        else
        begin
            state                  <= next_state;
            mastership_grant_n_out <= next_grant_n;
            bus_output_enable_out  <= next_bus_oe;
        end
    end

    // counts core cycles of grant low time, saturating, held cleared while grant is negated
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            hold_cnt <= '0;
        else if (mastership_grant_n_out)
            hold_cnt <= '0;
        else if (!hold_met)
            hold_cnt <= hold_cnt + `GRANT_CNT_W'(1);
    end

    // extended data enable: driven high first, floated half a period later;
    // re-enable happens together with the other outputs, no lag is needed there
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            extended_data_enable_n_out  <= 1'b1;
            extended_data_enable_oe_out <= 1'b0;
        end
        else
        begin
            extended_data_enable_n_out  <= next_bus_oe ? ext_data_enable_n_in : 1'b1;
            extended_data_enable_oe_out <= next_bus_oe | bus_output_enable_out;
        end
    end

    // timer count keeps its driver through outside mastership
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            timer_terminal_count_n_out <= 1'b1;
        else
            timer_terminal_count_n_out <= timer_terminal_count_n_in;
    end

    // bus inputs forced inactive while the outside master owns the bus
    assign read_buffer_clock_enable_n_out = granted_out | read_buffer_clock_enable_n_in;
    assign ack_n_out                      = granted_out | ack_n_in;
    assign transfer_error_n_out           = granted_out | transfer_error_n_in;

    // core keeps running from cache and only stalls on a bus need;
    // no snooping exists, so cache and write buffer coherency is left to software
    assign cpu_stall_out = granted_out & cpu_bus_need_in;

endmodule

// ---- pkg/mastership_regs.svh ----
// timing counts for the bus mastership arbiter
`ifndef MASTERSHIP_REGS_SVH
`define MASTERSHIP_REGS_SVH

// core clock period in picoseconds, 250 MHz
`define CORE_CLK_PERIOD_PS 4000
// system clock output period in core clock cycles
`define SYS_PERIOD_CORE_CYCLES 2
// least grant low time, in tenths of a system clock period (1.5 periods)
`define GRANT_MIN_HOLD_TENTHS 15
// least grant low time in core cycles (half system periods), rounded up
`define GRANT_MIN_HOLD_CYCLES \
    ((`GRANT_MIN_HOLD_TENTHS * `SYS_PERIOD_CORE_CYCLES + 9) / 10)
// width of the grant hold counter
`define GRANT_CNT_W 3
// reset value of the grant output, negated
`define GRANT_RESET_N 1'b1

`endif

// ---- pkg/mastership_pkg.sv ----
// types shared by the bus mastership arbiter
package mastership_pkg;

    // ownership of the external bus as seen by the arbiter
    typedef enum logic [1:0] {
        CPU_OWNS,
        GRANTED,
        RELEASING,
        RESUMING
    } owner_state_t;

endpackage

// ---- hdl/level_sync.sv ----
// two flip-flop level synchroniser, parameterised width
`timescale 1ns/1ps

module level_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    // asynchronous level in, synchronised level out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            meta     <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// ---- dv/dma_master_model.sv ----
// outside bus master model driving the request line
`timescale 1ns/1ps

module dma_master_model (
    // clock
    input  wire logic clk_in,
    // bench command and pin outputs
    input  wire logic want_in,
    output logic      req_n_out,
    output logic      drive_oe_out
);
    initial req_n_out = 1'b1;
    initial drive_oe_out = 1'b0;

    // drivers drop with the request, never later, so the resume edge sees no clash
    always @(posedge clk_in)
    begin
        // bench keeps the request off for several clocks between handovers
        req_n_out <= !want_in;
        // drivers come up no earlier than the request, leaving room to delay use of grant
        drive_oe_out <= want_in;
    end
endmodule

// ---- dv/mastership_arbiter_chk.sv ----
// concurrent checks on the bus mastership arbiter ports
`timescale 1ns/1ps

module mastership_arbiter_chk #(
    parameter int HOLD_CYCLES = 3
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic protocol_select_in,
    input wire logic mastership_request_n_in,
    input wire logic mastership_grant_n_out,
    input wire logic cpu_bus_need_in,
    input wire logic transfer_busy_in,
    input wire logic bus_output_enable_out,
    input wire logic extended_data_enable_n_out,
    input wire logic extended_data_enable_oe_out,
    input wire logic ack_n_out,
    input wire logic system_clock_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    grant_hold_a: assert property
        ($fell(mastership_grant_n_out) |-> !mastership_grant_n_out [*3]) else $error("grant short");
    default_keep_a: assert property
        ((!protocol_select_in && !mastership_request_n_in)[*3] ##0 !mastership_grant_n_out
        |=> !mastership_grant_n_out) else $error("grant dropped");
    grant_start_a: assert property
        ($fell(mastership_grant_n_out) |-> $fell(bus_output_enable_out) && !$past(system_clock_out)
        && !$past(transfer_busy_in)) else $error("bad grant start");
    ext_lag_a: assert property
        ($fell(bus_output_enable_out) |-> extended_data_enable_oe_out && extended_data_enable_n_out
        ##1 !extended_data_enable_oe_out) else $error("ext enable lag");
    stay_float_a: assert property
        (!bus_output_enable_out && !mastership_request_n_in |=> !bus_output_enable_out)
        else $error("early resume");
    default_fall_a: assert property
        ($rose(mastership_grant_n_out) && !$past(protocol_select_in) |-> $past(system_clock_out))
        else $error("grant not on falling edge");
    early_drop_a: assert property
        ($rose(mastership_grant_n_out) && !$past(system_clock_out)
        |-> $past(protocol_select_in) && $past(cpu_bus_need_in)) else $error("bad early drop");
    ignore_in_a: assert property
        (!bus_output_enable_out |-> ack_n_out) else $error("ack seen while floating");
endmodule

bind mastership_arbiter mastership_arbiter_chk #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
    .core_clk_in, .resetn_in, .protocol_select_in, .mastership_request_n_in,
    .mastership_grant_n_out, .cpu_bus_need_in, .transfer_busy_in, .bus_output_enable_out,
    .extended_data_enable_n_out, .extended_data_enable_oe_out, .ack_n_out, .system_clock_out);

// ---- dv/mastership_arbiter_tb_top.sv ----
// testbench for the bus mastership arbiter
`timescale 1ns/1ps

module mastership_arbiter_tb_top;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic prot = 1'b0, need = 1'b0, busy = 1'b0, ack_n = 1'b1, tmr = 1'b1, want = 1'b0;
    logic req_n, gnt_n, stall, bus_oe, ext_n, ext_oe, rbce, ack_o, err_o, sclk, tmr_o, drv;
    int n_fail = 0;
    int compares = 0;

    always #2 core_clk_in = ~core_clk_in;

    dma_master_model far (.clk_in(core_clk_in), .want_in(want), .req_n_out(req_n),
        .drive_oe_out(drv));

    mastership_arbiter #(.HOLD_CYCLES(3)) DUT (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .protocol_select_in(prot), .mastership_request_n_in(req_n),
        .mastership_grant_n_out(gnt_n), .cpu_bus_need_in(need), .transfer_busy_in(busy),
        .cpu_stall_out(stall), .bus_output_enable_out(bus_oe), .ext_data_enable_n_in(tmr),
        .extended_data_enable_n_out(ext_n), .extended_data_enable_oe_out(ext_oe),
        .read_buffer_clock_enable_n_in(ack_n), .ack_n_in(ack_n), .transfer_error_n_in(ack_n),
        .read_buffer_clock_enable_n_out(rbce), .ack_n_out(ack_o), .transfer_error_n_out(err_o),
        .timer_terminal_count_n_in(tmr), .system_clock_out(sclk), .timer_terminal_count_n_out(tmr_o));

    task automatic check(input string what, input logic seen, input logic exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %b seen %b", what, exp, seen);
        end
    endtask

    // bounded wait so a stuck handshake shows up as a mismatch, not a hang
    task automatic wait_for(ref logic s, input logic v, input string what);
        repeat (40)
            if (s !== v)
            begin
                @(posedge core_clk_in);
                #1;
            end
        check(what, s, v);
    endtask

    // one mastership handover under the given protocol and core demand
    task automatic t_cycle(input logic p, input logic nd);
        @(posedge core_clk_in);
        prot <= p;
        need <= nd;
        ack_n <= 1'b0;
        want <= 1'b1;
        wait_for(gnt_n, 1'b0, "grant");
        check("bus_oe", bus_oe, 1'b0);
        check("ack", ack_o & rbce & err_o, 1'b1);
        check("stall", stall, nd);
        check("ext driven high", ext_n, 1'b1);
        @(posedge core_clk_in);
        tmr <= 1'b0;
        @(posedge core_clk_in);
        #1;
        check("timer", tmr_o, 1'b0);
        check("ext_oe", ext_oe, 1'b0);
        if (p && nd)
            wait_for(gnt_n, 1'b1, "early drop");
        else
            repeat (10) @(posedge core_clk_in);
        #1;
        check("grant held", gnt_n, p && nd);
        check("still floating", bus_oe, 1'b0);
        @(posedge core_clk_in);
        want <= 1'b0;
        ack_n <= 1'b1;
        tmr <= 1'b1;
        need <= 1'b0;
        wait_for(bus_oe, 1'b1, "resume");
        check("grant off", gnt_n, 1'b1);
        check("ext back", ext_oe, 1'b1);
    endtask

    // request during a transfer waits until it ends
    task automatic t_busy();
        @(posedge core_clk_in);
        busy <= 1'b1;
        want <= 1'b1;
        repeat (12) @(posedge core_clk_in);
        #1;
        check("held off", gnt_n, 1'b1);
        @(posedge core_clk_in);
        busy <= 1'b0;
        wait_for(gnt_n, 1'b0, "late grant");
        @(posedge core_clk_in);
        want <= 1'b0;
        wait_for(bus_oe, 1'b1, "resume");
    endtask

    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge core_clk_in);
        #1;
        check("reset grant", gnt_n, 1'b1);
        check("reset system_clock_out", sclk, 1'b0);
        @(posedge core_clk_in);
        resetn_in <= 1'b1;
        @(posedge core_clk_in);
        #1;
        check("bus driven", bus_oe, 1'b1);
        check("system_clock_out runs", sclk, 1'b1);
        t_cycle(1'b0, 1'b0);
        t_cycle(1'b0, 1'b1);
        t_cycle(1'b1, 1'b1);
        t_cycle(1'b1, 1'b0);
        t_busy();
        conclude();
    end

    // watchdog well beyond the hundred-odd cycles the run needs
    initial
    begin
        #20000;
        n_fail++;
        conclude();
    end
endmodule
